/* File: hw/acl_match_pkg.sv */
// Shared types, register map and field layout of the IPv4 filter entry matcher
package acl_match_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int unsigned REG_ADDR_W = 8;
  localparam int unsigned REG_DATA_W = 32;
  localparam int unsigned CNT_W = 32;

  // ==========================================================================
  // Register offsets (byte addresses, one word each)
  // ==========================================================================
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PROTO = 8'h04;
  localparam logic [7:0] OFS_SRC_ADDR = 8'h08;
  localparam logic [7:0] OFS_SRC_MASK = 8'h0c;
  localparam logic [7:0] OFS_DST_ADDR = 8'h10;
  localparam logic [7:0] OFS_DST_MASK = 8'h14;
  localparam logic [7:0] OFS_FRAME_CNT = 8'h18;
  localparam logic [7:0] OFS_HIT_CNT = 8'h1c;

  // ==========================================================================
  // Control register field positions (low bit of each field)
  // ==========================================================================
  localparam int unsigned POS_FTYPE = 0;
  localparam int unsigned POS_PROTO_MODE = 4;
  localparam int unsigned POS_TTL_MODE = 8;
  localparam int unsigned POS_FRAG_MODE = 10;
  localparam int unsigned POS_OPT_MODE = 12;
  localparam int unsigned POS_SRC_MODE = 16;
  localparam int unsigned POS_DST_MODE = 18;

  // ==========================================================================
  // Fixed protocol numbers of the shortcut selections
  // ==========================================================================
  localparam logic [7:0] PROTO_NUM_ICMP = 8'h01;
  localparam logic [7:0] PROTO_NUM_TCP = 8'h06;
  localparam logic [7:0] PROTO_NUM_UDP = 8'h11;

  // ==========================================================================
  // Modes
  // ==========================================================================
  typedef enum logic [2:0] {
    FT_ANY = 3'b000,
    FT_ETH = 3'b001,
    FT_ARP = 3'b010,
    FT_IPV4 = 3'b011,
    FT_IPV6 = 3'b100
  } frame_type_e;

  typedef enum logic [2:0] {
    PM_ANY = 3'b000,
    PM_SPECIFIC = 3'b001,
    PM_ICMP = 3'b010,
    PM_UDP = 3'b011,
    PM_TCP = 3'b100
  } proto_mode_e;

  typedef enum logic [1:0] {
    TTL_ANY = 2'b00,
    TTL_ZERO = 2'b01,
    TTL_NONZERO = 2'b10
  } ttl_mode_e;

  // Shared by the fragment and options settings
  typedef enum logic [1:0] {
    YN_ANY = 2'b00,
    YN_NO = 2'b01,
    YN_YES = 2'b10
  } yes_no_e;

  typedef enum logic [1:0] {
    AF_ANY = 2'b00,
    AF_HOST = 2'b01,
    AF_NETWORK = 2'b10
  } addr_mode_e;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [31:0] RST_ADDR = 32'h0000_0000;
  localparam logic [31:0] RST_MASK = 32'hffff_ffff;
  localparam logic [7:0] RST_PROTO = 8'h00;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic valid;
    frame_type_e ftype;
    logic [7:0] proto;
    logic [7:0] ttl;
    logic more_frag;
    logic [12:0] frag_off;
    logic opts;
    logic [31:0] src_ip;
    logic [31:0] dst_ip;
  } frame_s;

  typedef struct packed {
    frame_type_e ftype;
    proto_mode_e proto_mode;
    logic [7:0] proto;
    ttl_mode_e ttl_mode;
    yes_no_e frag_mode;
    yes_no_e opt_mode;
    addr_mode_e source_ip_filter;
    logic [31:0] src_addr;
    logic [31:0] src_mask;
    addr_mode_e dest_ip_filter;
    logic [31:0] dst_addr;
    logic [31:0] dst_mask;
  } filter_entry_s;

endpackage

/* File: hw/ipv4_acl_entry_matcher.sv */
// One filter entry: IPv4 criteria classification with a small register port
//
// Behaviour
// - IPv4 criteria count only when the entry's frame type selects IPv4.
// - Protocol filter any ignores the frame's protocol field.
// - Protocol filter specific: 8-bit value, frame protocol must equal it.
// - ICMP, UDP and TCP selections demand that protocol number.
// - TTL setting zero: frames with TTL above zero never hit.
// - TTL setting non-zero: frames with TTL above zero may hit.
// - Fragment setting no: frames with MF or nonzero offset never hit.
// - Fragment setting yes: fragmented frames may hit.
// - Options setting no: frames with the options flag never hit.
// - Options setting yes: frames with the options flag may hit.
// - Source filter any ignores the source address.
// - Source filter host compares all 32 source address bits.
// - Source filter network compares only bits set in the source mask.
// - Destination filter any ignores the destination address.
// - Destination filter host compares the full destination address.
// - Destination filter network compares only bits set in the destination mask.
module ipv4_acl_entry_matcher
  import acl_match_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire frame_s frame_in,
  input wire logic [REG_ADDR_W-1:0] reg_addr_in,
  input wire logic [REG_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [REG_DATA_W-1:0] reg_rdata_out,
  output logic hit_out,
  output logic hit_valid_out
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    filter_entry_s cfg;
    logic hit;
    logic hit_valid;
    logic [REG_DATA_W-1:0] rdata;
    logic [CNT_W-1:0] frame_cnt;
    logic [CNT_W-1:0] hit_cnt;
  } state_s;

  state_s st_q;
  state_s st_d;

  // ==========================================================================
  // Decoding helpers
  // ==========================================================================
  // Used for both source and destination address filters
  function automatic logic addr_ok(input addr_mode_e mode, input logic [31:0] frm,
                                   input logic [31:0] ent, input logic [31:0] mask);
    logic ok;
    ok = 1'b0;
    unique case (mode)
      AF_ANY: ok = 1'b1;
      AF_HOST: ok = (frm == ent);
      AF_NETWORK: ok = ((frm & mask) == (ent & mask));
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Used for both the fragment and the options setting
  function automatic logic yes_no_ok(input yes_no_e mode, input logic flag);
    logic ok;
    ok = 1'b0;
    unique case (mode)
      YN_ANY: ok = 1'b1;
      YN_NO: ok = !flag;
      YN_YES: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // ==========================================================================
  // Criteria
  // ==========================================================================
  logic proto_ok;
  logic ttl_ok;
  logic frag_ok;
  logic opt_ok;
  logic src_ok;
  logic dst_ok;
  logic ipv4_ok;
  logic entry_hit;

  always_comb begin
    proto_ok = 1'b0;
    unique case (st_q.cfg.proto_mode)
      PM_ANY: proto_ok = 1'b1;
      PM_SPECIFIC: proto_ok = (frame_in.proto == st_q.cfg.proto);
      PM_ICMP: proto_ok = (frame_in.proto == PROTO_NUM_ICMP);
      PM_UDP: proto_ok = (frame_in.proto == PROTO_NUM_UDP);
      PM_TCP: proto_ok = (frame_in.proto == PROTO_NUM_TCP);
      default: proto_ok = 1'b0;
    endcase
  end

  // A non-zero setting asks for a live packet, so TTL of zero is refused
  always_comb begin
    ttl_ok = 1'b0;
    unique case (st_q.cfg.ttl_mode)
      TTL_ANY: ttl_ok = 1'b1;
      TTL_ZERO: ttl_ok = (frame_in.ttl == 8'h00);
      TTL_NONZERO: ttl_ok = (frame_in.ttl != 8'h00);
      default: ttl_ok = 1'b0;
    endcase
  end

  assign frag_ok = yes_no_ok(st_q.cfg.frag_mode, frame_in.more_frag || (frame_in.frag_off != 13'h0000));
  assign opt_ok = yes_no_ok(st_q.cfg.opt_mode, frame_in.opts);
  assign src_ok = addr_ok(st_q.cfg.source_ip_filter, frame_in.src_ip, st_q.cfg.src_addr, st_q.cfg.src_mask);
  assign dst_ok = addr_ok(st_q.cfg.dest_ip_filter, frame_in.dst_ip, st_q.cfg.dst_addr, st_q.cfg.dst_mask);
  assign ipv4_ok = proto_ok && ttl_ok && frag_ok && opt_ok && src_ok && dst_ok;

  // Non-IPv4 entries match on frame type alone
  always_comb begin
    entry_hit = 1'b0;
    unique case (st_q.cfg.ftype)
      FT_ANY: entry_hit = 1'b1;
      FT_IPV4: entry_hit = (frame_in.ftype == FT_IPV4) && ipv4_ok;
      default: entry_hit = (frame_in.ftype == st_q.cfg.ftype);
    endcase
  end

  // ==========================================================================
  // Next state: registers, read port, verdict, counters
  // ==========================================================================
  always_comb begin
    st_d = st_q;
    st_d.hit_valid = frame_in.valid;
    st_d.hit = frame_in.valid && entry_hit;
    if (frame_in.valid) begin
      st_d.frame_cnt = CNT_W'(st_q.frame_cnt + 1'b1);
    end
    if (frame_in.valid && entry_hit) begin
      st_d.hit_cnt = CNT_W'(st_q.hit_cnt + 1'b1);
    end
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        OFS_CTRL: begin
          st_d.cfg.ftype = frame_type_e'(reg_wdata_in[POS_FTYPE +: 3]);
          st_d.cfg.proto_mode = proto_mode_e'(reg_wdata_in[POS_PROTO_MODE +: 3]);
          st_d.cfg.ttl_mode = ttl_mode_e'(reg_wdata_in[POS_TTL_MODE +: 2]);
          st_d.cfg.frag_mode = yes_no_e'(reg_wdata_in[POS_FRAG_MODE +: 2]);
          st_d.cfg.opt_mode = yes_no_e'(reg_wdata_in[POS_OPT_MODE +: 2]);
          st_d.cfg.source_ip_filter = addr_mode_e'(reg_wdata_in[POS_SRC_MODE +: 2]);
          st_d.cfg.dest_ip_filter = addr_mode_e'(reg_wdata_in[POS_DST_MODE +: 2]);
        end
        OFS_PROTO: st_d.cfg.proto = reg_wdata_in[7:0];
        OFS_SRC_ADDR: st_d.cfg.src_addr = reg_wdata_in;
        OFS_SRC_MASK: st_d.cfg.src_mask = reg_wdata_in;
        OFS_DST_ADDR: st_d.cfg.dst_addr = reg_wdata_in;
        OFS_DST_MASK: st_d.cfg.dst_mask = reg_wdata_in;
        // Each counter clears on any write to its own offset; a frame in the same cycle still counts
        OFS_FRAME_CNT: st_d.frame_cnt = frame_in.valid ? CNT_W'(1) : '0;
        OFS_HIT_CNT: st_d.hit_cnt = (frame_in.valid && entry_hit) ? CNT_W'(1) : '0;
        default: ;
      endcase
    end
    st_d.rdata = '0;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        OFS_CTRL: begin
          st_d.rdata[POS_FTYPE +: 3] = st_q.cfg.ftype;
          st_d.rdata[POS_PROTO_MODE +: 3] = st_q.cfg.proto_mode;
          st_d.rdata[POS_TTL_MODE +: 2] = st_q.cfg.ttl_mode;
          st_d.rdata[POS_FRAG_MODE +: 2] = st_q.cfg.frag_mode;
          st_d.rdata[POS_OPT_MODE +: 2] = st_q.cfg.opt_mode;
          st_d.rdata[POS_SRC_MODE +: 2] = st_q.cfg.source_ip_filter;
          st_d.rdata[POS_DST_MODE +: 2] = st_q.cfg.dest_ip_filter;
        end
        OFS_PROTO: st_d.rdata[7:0] = st_q.cfg.proto;
        OFS_SRC_ADDR: st_d.rdata = st_q.cfg.src_addr;
        OFS_SRC_MASK: st_d.rdata = st_q.cfg.src_mask;
        OFS_DST_ADDR: st_d.rdata = st_q.cfg.dst_addr;
        OFS_DST_MASK: st_d.rdata = st_q.cfg.dst_mask;
        OFS_FRAME_CNT: st_d.rdata = st_q.frame_cnt;
        OFS_HIT_CNT: st_d.rdata = st_q.hit_cnt;
        default: st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
      st_q.cfg.src_addr <= RST_ADDR;
      st_q.cfg.src_mask <= RST_MASK;
      st_q.cfg.dst_addr <= RST_ADDR;
      st_q.cfg.dst_mask <= RST_MASK;
      st_q.cfg.proto <= RST_PROTO;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata_out = st_q.rdata;
  assign hit_out = st_q.hit;
  assign hit_valid_out = st_q.hit_valid;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_type_only;
    frame_in.valid && !reg_wr_in && st_q.cfg.ftype != FT_IPV4 && st_q.cfg.ftype != FT_ANY
      |=> hit_out == ($past(frame_in.ftype) == $past(st_q.cfg.ftype));
  endproperty
  a_type_only: assert property (p_type_only) else $error("non-IPv4 entry used IPv4 criteria");

  property p_all_any;
    frame_in.valid && st_q.cfg.ftype == FT_IPV4 && frame_in.ftype == FT_IPV4
      && st_q.cfg.proto_mode == PM_ANY && st_q.cfg.ttl_mode == TTL_ANY && st_q.cfg.frag_mode == YN_ANY
      && st_q.cfg.opt_mode == YN_ANY && st_q.cfg.source_ip_filter == AF_ANY && st_q.cfg.dest_ip_filter == AF_ANY
      |=> hit_out && hit_valid_out;
  endproperty
  a_all_any: assert property (p_all_any) else $error("all-any IPv4 entry missed");

  property p_proto_spec;
    frame_in.valid && st_q.cfg.ftype == FT_IPV4 && st_q.cfg.proto_mode == PM_SPECIFIC
      && frame_in.proto != st_q.cfg.proto |=> !hit_out;
  endproperty
  a_proto_spec: assert property (p_proto_spec) else $error("protocol mismatch hit");

  property p_proto_udp;
    frame_in.valid && st_q.cfg.ftype == FT_IPV4 && st_q.cfg.proto_mode == PM_UDP
      && frame_in.proto != PROTO_NUM_UDP |=> !hit_out;
  endproperty
  a_proto_udp: assert property (p_proto_udp) else $error("UDP entry hit other protocol");

  property p_ttl_zero;
    frame_in.valid && st_q.cfg.ftype == FT_IPV4 && st_q.cfg.ttl_mode == TTL_ZERO
      && frame_in.ttl != 8'h00 |=> !hit_out;
  endproperty
  a_ttl_zero: assert property (p_ttl_zero) else $error("live TTL hit zero entry");

  property p_frag_no;
    frame_in.valid && st_q.cfg.ftype == FT_IPV4 && st_q.cfg.frag_mode == YN_NO
      && (frame_in.more_frag || frame_in.frag_off != 13'h0000) |=> !hit_out;
  endproperty
  a_frag_no: assert property (p_frag_no) else $error("fragment hit no-fragment entry");

  property p_opt_no;
    frame_in.valid && st_q.cfg.ftype == FT_IPV4 && st_q.cfg.opt_mode == YN_NO && frame_in.opts |=> !hit_out;
  endproperty
  a_opt_no: assert property (p_opt_no) else $error("options frame hit no-options entry");

  property p_src_host;
    frame_in.valid && st_q.cfg.ftype == FT_IPV4 && st_q.cfg.source_ip_filter == AF_HOST
      && frame_in.src_ip != st_q.cfg.src_addr |=> !hit_out;
  endproperty
  a_src_host: assert property (p_src_host) else $error("source host mismatch hit");

  property p_dst_net;
    frame_in.valid && st_q.cfg.ftype == FT_IPV4 && st_q.cfg.dest_ip_filter == AF_NETWORK
      && ((frame_in.dst_ip ^ st_q.cfg.dst_addr) & st_q.cfg.dst_mask) != 32'h0000_0000 |=> !hit_out;
  endproperty
  a_dst_net: assert property (p_dst_net) else $error("destination network mismatch hit");

  property p_verdict_follows;
    frame_in.valid |=> hit_valid_out ##1 (hit_valid_out == $past(frame_in.valid));
  endproperty
  a_verdict_follows: assert property (p_verdict_follows) else $error("verdict not one cycle after frame");

  // Which criteria are left at any, so that a hit can be demanded of the one under test
  logic [5:0] crit_any;
  logic ipv4_both;
  assign crit_any = {st_q.cfg.proto_mode == PM_ANY, st_q.cfg.ttl_mode == TTL_ANY,
    st_q.cfg.frag_mode == YN_ANY, st_q.cfg.opt_mode == YN_ANY,
    st_q.cfg.source_ip_filter == AF_ANY, st_q.cfg.dest_ip_filter == AF_ANY};
  assign ipv4_both = frame_in.valid && st_q.cfg.ftype == FT_IPV4 && frame_in.ftype == FT_IPV4;

  property p_proto_icmp;
    frame_in.valid && st_q.cfg.ftype == FT_IPV4 && st_q.cfg.proto_mode == PM_ICMP
      && frame_in.proto != PROTO_NUM_ICMP |=> !hit_out;
  endproperty
  a_proto_icmp: assert property (p_proto_icmp) else $error("ICMP entry hit other protocol");

  property p_proto_hit;
    ipv4_both && st_q.cfg.proto_mode == PM_SPECIFIC && frame_in.proto == st_q.cfg.proto
      && crit_any[4:0] == 5'h1f |=> hit_out;
  endproperty
  a_proto_hit: assert property (p_proto_hit) else $error("matching protocol missed");

  property p_ttl_live;
    ipv4_both && st_q.cfg.ttl_mode == TTL_NONZERO && frame_in.ttl != 8'h00
      && crit_any[5] && crit_any[3:0] == 4'hf |=> hit_out;
  endproperty
  a_ttl_live: assert property (p_ttl_live) else $error("live TTL missed non-zero entry");

  property p_frag_yes;
    ipv4_both && st_q.cfg.frag_mode == YN_YES
      && crit_any[5:4] == 2'b11 && crit_any[2:0] == 3'b111 |=> hit_out;
  endproperty
  a_frag_yes: assert property (p_frag_yes) else $error("fragment-yes entry missed");

  property p_opt_yes;
    ipv4_both && st_q.cfg.opt_mode == YN_YES
      && crit_any[5:3] == 3'b111 && crit_any[1:0] == 2'b11 |=> hit_out;
  endproperty
  a_opt_yes: assert property (p_opt_yes) else $error("options-yes entry missed");

  property p_src_host_hit;
    ipv4_both && st_q.cfg.source_ip_filter == AF_HOST && frame_in.src_ip == st_q.cfg.src_addr
      && crit_any[5:2] == 4'hf && crit_any[0] |=> hit_out;
  endproperty
  a_src_host_hit: assert property (p_src_host_hit) else $error("source host match missed");

  property p_src_net;
    frame_in.valid && st_q.cfg.ftype == FT_IPV4 && st_q.cfg.source_ip_filter == AF_NETWORK
      && ((frame_in.src_ip ^ st_q.cfg.src_addr) & st_q.cfg.src_mask) != 32'h0000_0000 |=> !hit_out;
  endproperty
  a_src_net: assert property (p_src_net) else $error("source network mismatch hit");

  property p_dst_host;
    frame_in.valid && st_q.cfg.ftype == FT_IPV4 && st_q.cfg.dest_ip_filter == AF_HOST
      && frame_in.dst_ip != st_q.cfg.dst_addr |=> !hit_out;
  endproperty
  a_dst_host: assert property (p_dst_host) else $error("destination host mismatch hit");

  property p_dst_net_hit;
    ipv4_both && st_q.cfg.dest_ip_filter == AF_NETWORK && crit_any[5:1] == 5'h1f
      && ((frame_in.dst_ip ^ st_q.cfg.dst_addr) & st_q.cfg.dst_mask) == 32'h0000_0000 |=> hit_out;
  endproperty
  a_dst_net_hit: assert property (p_dst_net_hit) else $error("destination network match missed");

  property p_wrong_type;
    frame_in.valid && st_q.cfg.ftype == FT_IPV4 && frame_in.ftype != FT_IPV4 |=> !hit_out;
  endproperty
  a_wrong_type: assert property (p_wrong_type) else $error("IPv4 entry hit other frame type");

  property p_any_type;
    frame_in.valid && st_q.cfg.ftype == FT_ANY |=> hit_out;
  endproperty
  a_any_type: assert property (p_any_type) else $error("any-type entry missed");

endmodule

/* File: dv/frame_source.sv */
// Ingress port model that hands received frames to the entry matcher
module frame_source
  import acl_match_pkg::*;
(
  input wire logic ref_clk_in,
  input wire frame_s req_in,
  output frame_s frame_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Frame launch
  // ==========================================================================
  frame_s held_q = '0;

  // Between frames the fields toggle so a stale header is never mistaken for a fresh one
  always @(posedge ref_clk_in) begin
    if (req_in.valid) begin
      held_q <= req_in;
    end else begin
      held_q <= {1'b0, ~held_q[$bits(frame_s)-2:0]};
    end
  end

  assign frame_out = held_q;
endmodule

/* File: dv/tb_ipv4_acl_entry_matcher.sv */
// Self-checking bench of the IPv4 filter entry matcher
module tb_ipv4_acl_entry_matcher;
  import acl_match_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals
  // ==========================================================================
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  frame_s req = '0;
  frame_s frame_w;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic hit, hit_valid;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] ctrl, sa, sm, da, dm, nfr, nhit, d;
  logic [7:0] pv;

  always #12.5 ref_clk_in = ~ref_clk_in;

  frame_source frame_source_inst (.ref_clk_in(ref_clk_in), .req_in(req), .frame_out(frame_w));

  ipv4_acl_entry_matcher ipv4_acl_entry_matcher_inst (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .frame_in(frame_w), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
    .hit_out(hit), .hit_valid_out(hit_valid));

  // ==========================================================================
  // Checking and closing
  // ==========================================================================
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // A full run costs far fewer cycles than this ceiling
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      close_out();
    end
  end

  // ==========================================================================
  // Expected verdict
  // ==========================================================================
  function automatic logic amatch(input logic [1:0] m, input logic [31:0] a, input logic [31:0] e,
                                  input logic [31:0] k);
    case (m)
      2'd0: return 1'b1;
      2'd1: return a == e;
      2'd2: return (a & k) == (e & k);
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic expect_hit(input frame_s f);
    logic fr, ok;
    if (ctrl[2:0] == 3'd0) return 1'b1;
    if (ctrl[2:0] != 3'd3) return f.ftype == ctrl[2:0];
    if (f.ftype != FT_IPV4) return 1'b0;
    case (ctrl[6:4])
      3'd0: ok = 1'b1;
      3'd1: ok = f.proto == pv;
      3'd2: ok = f.proto == PROTO_NUM_ICMP;
      3'd3: ok = f.proto == PROTO_NUM_UDP;
      3'd4: ok = f.proto == PROTO_NUM_TCP;
      default: ok = 1'b0;
    endcase
    ok &= (ctrl[9:8] == 2'd0) || (ctrl[9:8] == 2'd1 && f.ttl == 8'h00) ||
          (ctrl[9:8] == 2'd2 && f.ttl != 8'h00);
    fr = f.more_frag || (f.frag_off != 13'h0000);
    ok &= (ctrl[11:10] == 2'd0) || (ctrl[11:10] == 2'd1 && !fr) || (ctrl[11:10] == 2'd2);
    ok &= (ctrl[13:12] == 2'd0) || (ctrl[13:12] == 2'd1 && !f.opts) || (ctrl[13:12] == 2'd2);
    return ok && amatch(ctrl[17:16], f.src_ip, sa, sm) && amatch(ctrl[19:18], f.dst_ip, da, dm);
  endfunction

  // ==========================================================================
  // Bus and frame tasks
  // ==========================================================================
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_in);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk_in);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk_in);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk_in);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic config_entry(input logic [31:0] c);
    ctrl = c;
    pv = 8'($urandom);
    sa = $urandom;
    sm = $urandom;
    da = $urandom;
    dm = $urandom;
    wr(OFS_CTRL, ctrl);
    wr(OFS_PROTO, {24'h0, pv});
    wr(OFS_SRC_ADDR, sa);
    wr(OFS_SRC_MASK, sm);
    wr(OFS_DST_ADDR, da);
    wr(OFS_DST_MASK, dm);
  endtask

  task automatic send_frames(input int n);
    frame_s f;
    logic e;
    int p;
    repeat (n) begin
      f.valid = 1'b1;
      f.ftype = frame_type_e'(($urandom % 4 == 0) ? $urandom % 5 : 3);
      p = $urandom % 5;
      f.proto = p == 0 ? pv : p == 1 ? PROTO_NUM_ICMP : p == 2 ? PROTO_NUM_TCP : p == 3 ? PROTO_NUM_UDP : 8'($urandom);
      f.ttl = ($urandom % 2) ? 8'h00 : 8'($urandom);
      f.more_frag = $urandom % 4 == 0;
      f.frag_off = ($urandom % 4 == 0) ? 13'($urandom) : 13'h0000;
      f.opts = 1'($urandom % 2);
      // Exact entry addresses too, or a host filter would never be seen to hit
      f.src_ip = ($urandom % 2) ? sa ^ (($urandom % 2) ? ($urandom & ~sm) : 32'h0) : $urandom;
      f.dst_ip = ($urandom % 2) ? da ^ (($urandom % 2) ? ($urandom & ~dm) : 32'h0) : $urandom;
      e = expect_hit(f);
      @(posedge ref_clk_in);
      #1 chk("idle hit_valid", {31'h0, hit_valid}, 32'h0);
      chk("idle hit", {31'h0, hit}, 32'h0);
      req <= f;
      @(posedge ref_clk_in);
      req.valid <= 1'b0;
      @(posedge ref_clk_in);
      #1 chk("hit_valid", {31'h0, hit_valid}, 32'h1);
      chk("hit", {31'h0, hit}, {31'h0, e});
      nfr++;
      nhit += e;
    end
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  int pos[7] = '{0, 4, 8, 10, 12, 16, 18};
  int nv[7] = '{5, 8, 4, 4, 4, 4, 4};

  initial begin
    void'($urandom(32'h15c8df6c));
    nfr = 0;
    nhit = 0;
    repeat (8) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rd(OFS_CTRL, d); chk("ctrl reset", d, 32'h0);
    rd(OFS_PROTO, d); chk("proto reset", d, {24'h0, RST_PROTO});
    rd(OFS_SRC_ADDR, d); chk("src addr reset", d, RST_ADDR);
    rd(OFS_SRC_MASK, d); chk("src mask reset", d, RST_MASK);
    rd(OFS_DST_ADDR, d); chk("dst addr reset", d, RST_ADDR);
    rd(OFS_DST_MASK, d); chk("dst mask reset", d, RST_MASK);
    rd(OFS_FRAME_CNT, d); chk("frame count reset", d, 32'h0);
    rd(OFS_HIT_CNT, d); chk("hit count reset", d, 32'h0);
    rd(8'h20, d); chk("unmapped read", d, 32'h0);
    $display("test reset_values done");
    // Every setting of every criterion, others left at any and frame type IPv4 outside its own sweep
    for (int k = 0; k < 7; k++) begin
      for (int v = 0; v < nv[k]; v++) begin
        config_entry(k == 0 ? 32'(v) : (32'h3 | (32'(v) << pos[k])));
        rd(OFS_CTRL, d); chk("ctrl readback", d, ctrl);
        rd(OFS_PROTO, d); chk("proto readback", d, {24'h0, pv});
        send_frames(10);
      end
    end
    $display("test mode_sweep done");
    repeat (60) begin
      config_entry((32'($urandom) & 32'h000f_3f70) | (($urandom % 4 == 0) ? 32'($urandom % 5) : 32'h3));
      rd(OFS_SRC_MASK, d); chk("src mask readback", d, sm);
      rd(OFS_DST_ADDR, d); chk("dst addr readback", d, da);
      send_frames(6);
    end
    $display("test random_entries done");
    rd(OFS_FRAME_CNT, d); chk("frame count", d, nfr);
    rd(OFS_HIT_CNT, d); chk("hit count", d, nhit);
    wr(OFS_HIT_CNT, 32'h0);
    rd(OFS_HIT_CNT, d); chk("hit count cleared", d, 32'h0);
    $display("test counters done");
    close_out();
  end
endmodule
